// File: flash_cmd_pkg.sv
// constants for the serial flash command decoder
// assumes one system clock that oversamples the serial clock pin
package flash_cmd_pkg;
  // opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_CONFIG_FETCH = 8'h15;
  localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;
  localparam logic [7:0] OP_QUAD_LANE_WRITE = 8'h38;
  localparam logic [7:0] OP_SMALL_AREA_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_WIDE_AREA_WIPE = 8'hD8;
  localparam logic [7:0] OP_WHOLE_ARRAY_WIPE_A = 8'h60;
  localparam logic [7:0] OP_WHOLE_ARRAY_WIPE_B = 8'hC7;
  localparam logic [7:0] OP_SINGLE_LANE_WRITE = 8'h02;
  localparam logic [7:0] OP_LOW_POWER_ENTRY = 8'hB9;
  localparam logic [7:0] OP_LOW_POWER_EXIT = 8'hAB;
  localparam logic [7:0] OP_PAUSE_A = 8'h75;
  localparam logic [7:0] OP_PAUSE_B = 8'hB0;
  localparam logic [7:0] OP_CONTINUE_A = 8'h7A;
  localparam logic [7:0] OP_CONTINUE_B = 8'h30;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9F;
  localparam logic [7:0] OP_MAKER_PART_ID = 8'h90;
  localparam logic [7:0] OP_OTP_WINDOW_ENTRY = 8'hB1;
  // field layout
  localparam int STATUS_UNLOCK_BIT = 1;
  localparam int ADDR_BYTES = 3;
  localparam int DUMMY_BYTES_ELECTRONIC = 3;
  localparam int DUMMY_BYTES_MAKER = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // timing
  localparam int SYS_CLK_MHZ = 250;
  localparam int SYNC_STAGES = 3;
  // decoder phases
  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA, PH_IGNORE
  } phase_type;
  // command classes
  typedef enum logic [3:0] {
    K_NONE, K_UNLOCK, K_LOCK, K_STAT_RD, K_CFG_RD, K_REG_WR, K_PROG1, K_PROG4,
    K_WIPE, K_PD_IN, K_PD_OUT, K_PAUSE, K_CONT, K_ID, K_OTP, K_EID
  } cmd_type;
endpackage

// File: data_fifo.sv
// small synchronous fifo for program data toward the array engine
// assumes both sides on sys_clk
`timescale 1ns/10ps
module data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // flush at frame start
  input wire logic flush
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q, rp_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // honest full and empty from pointer compare
  assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = wp_q != rp_q;
  assign out_data = mem[rp_q[AW-1:0]];
  // pointers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  // storage
  always_ff @(posedge sys_clk) begin
    if (push) mem[wp_q[AW-1:0]] <= in_data;
  end
endmodule // data_fifo

// File: serial_flash_command_decoder.sv
// serial flash opcode decoder for the non-read command set
// assumes pins from the host spi master, oversampled on sys_clk
// Notes on behaviour
// - 06 sets, 04 clears the unlock flag
// - 05 shifts out status register
// - 15 shifts out configuration register
// - 38 takes address, then quad-lane data
// - 52, D8 block wipes; 60/C7 whole array
// - 75/B0 pause, 7A/30 continue operation
// - B9 power down, AB exit, id after dummies
// - 90, two dummies, address, then two ids
// - B1 enters secured otp window mode
// - write commands other than 01 need byte-aligned chip select rise; 01 loads its registers per byte
// - program and erase need unlock flag set
// - sample on rising clock, shift on falling
`timescale 1ns/10ps
module serial_flash_command_decoder #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3C, // arbitrary value
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // spi pins
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe_n,
  // engine status inputs
  input wire logic engine_busy,
  input wire logic status_busy_bit,
  // command strobes toward the engines
  output logic unlock_clear_done,
  output logic prog_start,
  output logic prog_quad,
  output logic wipe_start,
  output logic [1:0] wipe_size,
  output logic [23:0] cmd_addr,
  output logic pause_strobe,
  output logic continue_strobe,
  output logic power_down,
  output logic otp_window,
  output logic [7:0] status_q_out,
  output logic [7:0] config_q_out,
  output logic write_unlock_flag,
  // program data stream
  output logic pd_valid,
  output logic [7:0] pd_data,
  input wire logic pd_ready,
  output logic pd_overflow
);
  initial begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end
  // three-stage synchronisers for the pins
  logic [2:0] cs_s, sck_s;
  logic [3:0] d1_q, d2_q, d3_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s <= 3'h7;
      sck_s <= 3'h0;
      d1_q <= 4'h0;
      d2_q <= 4'h0;
      d3_q <= 4'h0;
    end else begin
      cs_s <= {cs_s[1:0], chip_select_n};
      sck_s <= {sck_s[1:0], serial_clk};
      d1_q <= sio_in;
      d2_q <= d1_q;
      d3_q <= d2_q;
    end
  end
  // stable levels where second and third stages agree
  logic cs_lvl_q, sck_lvl_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_lvl_q <= 1'b1;
      sck_lvl_q <= 1'b0;
    end else begin
      if (cs_s[1] == cs_s[2]) cs_lvl_q <= cs_s[2];
      if (sck_s[1] == sck_s[2]) sck_lvl_q <= sck_s[2];
    end
  end
  wire cs_new = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_lvl_q;
  wire sck_new = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_lvl_q;
  wire cs_fall = cs_lvl_q && !cs_new;
  wire cs_rise = !cs_lvl_q && cs_new;
  wire active = !cs_lvl_q;
  wire sck_rise = active && !sck_lvl_q && sck_new;
  wire sck_fall = active && sck_lvl_q && !sck_new;
  // opcode classification
  function automatic flash_cmd_pkg::cmd_type classify(input logic [7:0] op);
    case (op)
      flash_cmd_pkg::OP_WRITE_UNLOCK: classify = flash_cmd_pkg::K_UNLOCK;
      flash_cmd_pkg::OP_WRITE_LOCK: classify = flash_cmd_pkg::K_LOCK;
      flash_cmd_pkg::OP_STATUS_FETCH: classify = flash_cmd_pkg::K_STAT_RD;
      flash_cmd_pkg::OP_CONFIG_FETCH: classify = flash_cmd_pkg::K_CFG_RD;
      flash_cmd_pkg::OP_STATUS_CONFIG_WRITE: classify = flash_cmd_pkg::K_REG_WR;
      flash_cmd_pkg::OP_QUAD_LANE_WRITE: classify = flash_cmd_pkg::K_PROG4;
      flash_cmd_pkg::OP_SINGLE_LANE_WRITE: classify = flash_cmd_pkg::K_PROG1;
      flash_cmd_pkg::OP_SMALL_AREA_WIPE,
      flash_cmd_pkg::OP_HALF_BLOCK_WIPE,
      flash_cmd_pkg::OP_WIDE_AREA_WIPE,
      flash_cmd_pkg::OP_WHOLE_ARRAY_WIPE_A,
      flash_cmd_pkg::OP_WHOLE_ARRAY_WIPE_B: classify = flash_cmd_pkg::K_WIPE;
      flash_cmd_pkg::OP_PAUSE_A, flash_cmd_pkg::OP_PAUSE_B: classify = flash_cmd_pkg::K_PAUSE;
      flash_cmd_pkg::OP_CONTINUE_A,
      flash_cmd_pkg::OP_CONTINUE_B: classify = flash_cmd_pkg::K_CONT;
      flash_cmd_pkg::OP_LOW_POWER_ENTRY: classify = flash_cmd_pkg::K_PD_IN;
      flash_cmd_pkg::OP_LOW_POWER_EXIT: classify = flash_cmd_pkg::K_PD_OUT;
      flash_cmd_pkg::OP_MAKER_PART_ID: classify = flash_cmd_pkg::K_ID;
      flash_cmd_pkg::OP_OTP_WINDOW_ENTRY: classify = flash_cmd_pkg::K_OTP;
      default: classify = flash_cmd_pkg::K_NONE;
    endcase
  endfunction
  // wipe size code: 0 sector, 1 half block, 2 block, 3 whole array
  function automatic logic [1:0] wipe_code(input logic [7:0] op);
    case (op)
      flash_cmd_pkg::OP_HALF_BLOCK_WIPE: wipe_code = 2'h1;
      flash_cmd_pkg::OP_WIDE_AREA_WIPE: wipe_code = 2'h2;
      flash_cmd_pkg::OP_WHOLE_ARRAY_WIPE_A, flash_cmd_pkg::OP_WHOLE_ARRAY_WIPE_B: wipe_code = 2'h3;
      default: wipe_code = 2'h0;
    endcase
  endfunction
  // shift state
  flash_cmd_pkg::phase_type ph_q;
  flash_cmd_pkg::cmd_type kind_q;
  logic [7:0] op_q, sh_q, out_q;
  logic [2:0] bit_q;
  logic [1:0] cnt_q;
  logic [23:0] addr_q;
  logic [7:0] status_q, config_q;
  logic unlock_q, pd_q, otp_q, out_en_q, rd_sel_q, wipe_whole_q;
  // bit assembly: quad data phase takes four lanes per rising edge
  wire quad_in = (ph_q == flash_cmd_pkg::PH_WDATA) && (kind_q == flash_cmd_pkg::K_PROG4);
  wire [7:0] sh_next = quad_in ? {sh_q[3:0], d3_q} : {sh_q[6:0], d3_q[0]};
  wire byte_done = sck_rise && (quad_in ? bit_q[0] : (bit_q == 3'h7));
  wire [2:0] bit_next = quad_in ? (bit_q + 3'h1) & 3'h1 : bit_q + 3'h1;
  wire flash_cmd_pkg::cmd_type op_kind = classify(sh_next);
  // during power down only exit is decoded
  wire flash_cmd_pkg::cmd_type eff_kind = (pd_q && op_kind != flash_cmd_pkg::K_PD_OUT)
                                          ? flash_cmd_pkg::K_NONE : op_kind;
  wire is_write_kind = kind_q inside {flash_cmd_pkg::K_UNLOCK, flash_cmd_pkg::K_LOCK,
      flash_cmd_pkg::K_REG_WR, flash_cmd_pkg::K_PROG1, flash_cmd_pkg::K_PROG4,
      flash_cmd_pkg::K_WIPE, flash_cmd_pkg::K_PAUSE, flash_cmd_pkg::K_CONT, flash_cmd_pkg::K_OTP};
  wire needs_unlock = kind_q inside {flash_cmd_pkg::K_PROG1, flash_cmd_pkg::K_PROG4,
      flash_cmd_pkg::K_WIPE, flash_cmd_pkg::K_REG_WR};
  wire aligned = (bit_q == 3'h0);
  wire whole_wipe = (kind_q == flash_cmd_pkg::K_WIPE) && (wipe_code(op_q) == 2'h3);
  // a frame is complete enough to execute at an aligned rise
  wire frame_ok = (ph_q == flash_cmd_pkg::PH_OPCODE && kind_q != flash_cmd_pkg::K_NONE
                   && !(kind_q inside {flash_cmd_pkg::K_REG_WR, flash_cmd_pkg::K_PROG1,
                   flash_cmd_pkg::K_PROG4}) && (kind_q != flash_cmd_pkg::K_WIPE || whole_wipe))
                  || (ph_q == flash_cmd_pkg::PH_WDATA && kind_q != flash_cmd_pkg::K_REG_WR)
                  || (kind_q == flash_cmd_pkg::K_REG_WR && ph_q == flash_cmd_pkg::PH_IGNORE)
                  || (kind_q == flash_cmd_pkg::K_WIPE && ph_q == flash_cmd_pkg::PH_IGNORE);
  logic seen_q;
  wire exec = cs_rise && seen_q && aligned && is_write_kind && frame_ok;
  wire unlock_ok = unlock_q || !needs_unlock;
  // fifo fill for program data
  wire fifo_ready;
  wire fifo_push = byte_done && (ph_q == flash_cmd_pkg::PH_WDATA) && unlock_q
                   && (kind_q == flash_cmd_pkg::K_PROG1 || kind_q == flash_cmd_pkg::K_PROG4);
  // phase and frame sequencing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= flash_cmd_pkg::PH_OPCODE;
      kind_q <= flash_cmd_pkg::K_NONE;
      op_q <= flash_cmd_pkg::BYTE_ZERO;
      sh_q <= flash_cmd_pkg::BYTE_ZERO;
      bit_q <= 3'h0;
      cnt_q <= 2'h0;
      addr_q <= 24'h000000;
      seen_q <= 1'b0;
    end else if (cs_fall) begin
      ph_q <= flash_cmd_pkg::PH_OPCODE;
      kind_q <= flash_cmd_pkg::K_NONE;
      bit_q <= 3'h0;
      cnt_q <= 2'h0;
      seen_q <= 1'b0;
    end else if (sck_rise) begin
      sh_q <= sh_next;
      bit_q <= byte_done ? 3'h0 : bit_next;
      if (byte_done) begin
        seen_q <= 1'b1;
        case (ph_q)
          flash_cmd_pkg::PH_OPCODE: begin
            op_q <= sh_next;
            kind_q <= eff_kind;
            cnt_q <= 2'h0;
            case (eff_kind)
              flash_cmd_pkg::K_PROG1, flash_cmd_pkg::K_PROG4: ph_q <= flash_cmd_pkg::PH_ADDR;
              flash_cmd_pkg::K_WIPE: ph_q <= (wipe_code(sh_next) == 2'h3)
                  ? flash_cmd_pkg::PH_OPCODE : flash_cmd_pkg::PH_ADDR;
              flash_cmd_pkg::K_STAT_RD, flash_cmd_pkg::K_CFG_RD: ph_q <= flash_cmd_pkg::PH_RDATA;
              flash_cmd_pkg::K_PD_OUT, flash_cmd_pkg::K_ID: ph_q <= flash_cmd_pkg::PH_DUMMY;
              flash_cmd_pkg::K_REG_WR: ph_q <= flash_cmd_pkg::PH_WDATA;
              flash_cmd_pkg::K_NONE: ph_q <= flash_cmd_pkg::PH_IGNORE;
              default: ph_q <= flash_cmd_pkg::PH_OPCODE;
            endcase
          end
          flash_cmd_pkg::PH_ADDR: begin
            addr_q <= {addr_q[15:0], sh_next};
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == 2'(flash_cmd_pkg::ADDR_BYTES - 1)) begin
              ph_q <= (kind_q == flash_cmd_pkg::K_WIPE)
                  ? flash_cmd_pkg::PH_IGNORE : flash_cmd_pkg::PH_WDATA;
            end
          end
          flash_cmd_pkg::PH_DUMMY: begin
            addr_q <= {addr_q[15:0], sh_next};
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == 2'(flash_cmd_pkg::DUMMY_BYTES_ELECTRONIC - 1)) begin
              ph_q <= flash_cmd_pkg::PH_RDATA;
              if (kind_q == flash_cmd_pkg::K_PD_OUT) kind_q <= flash_cmd_pkg::K_EID;
            end
          end
          flash_cmd_pkg::PH_WDATA: begin
            cnt_q <= cnt_q + 2'h1;
            if (kind_q == flash_cmd_pkg::K_REG_WR && cnt_q == 2'h1) begin
              ph_q <= flash_cmd_pkg::PH_IGNORE;
            end
          end
          default: ph_q <= ph_q;
        endcase
      end
    end
  end
  // output byte select and falling-edge shifter
  wire [7:0] read_byte = (kind_q == flash_cmd_pkg::K_STAT_RD) ? status_q_out
                       : (kind_q == flash_cmd_pkg::K_CFG_RD) ? config_q
                       : (kind_q == flash_cmd_pkg::K_EID) ? DEVICE_ID
                       : (addr_q[0] ^ rd_sel_q) ? DEVICE_ID : MAKER_ID;
  wire load_out = byte_done && ((ph_q == flash_cmd_pkg::PH_OPCODE
                   && (eff_kind == flash_cmd_pkg::K_STAT_RD || eff_kind == flash_cmd_pkg::K_CFG_RD))
                   || (ph_q == flash_cmd_pkg::PH_DUMMY
                   && cnt_q == 2'(flash_cmd_pkg::DUMMY_BYTES_ELECTRONIC - 1))
                   || ph_q == flash_cmd_pkg::PH_RDATA);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= flash_cmd_pkg::BYTE_ZERO;
      out_en_q <= 1'b0;
      rd_sel_q <= 1'b0;
    end else if (cs_fall || cs_rise) begin
      out_en_q <= 1'b0;
      rd_sel_q <= 1'b0;
    end else if (load_out) begin
      out_en_q <= 1'b1;
      if (!out_en_q) out_q <= 8'hFF;
    end else if (sck_fall && out_en_q) begin
      if (bit_q == 3'h0) begin
        out_q <= read_byte;
        if (ph_q == flash_cmd_pkg::PH_RDATA) rd_sel_q <= !rd_sel_q;
      end else begin
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end
  assign sio_out = {3'h0, out_q[7]};
  assign sio_oe_n = {3'h7, !out_en_q};
  // register and mode state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_q <= 1'b0;
      status_q <= flash_cmd_pkg::STATUS_RESET;
      config_q <= flash_cmd_pkg::CONFIG_RESET;
      pd_q <= 1'b0;
      otp_q <= 1'b0;
      wipe_whole_q <= 1'b0;
    end else begin
      if (byte_done && kind_q == flash_cmd_pkg::K_REG_WR && ph_q == flash_cmd_pkg::PH_WDATA
          && unlock_q) begin
        if (cnt_q == 2'h0) status_q <= sh_next;
        else config_q <= sh_next;
      end
      if (exec && kind_q == flash_cmd_pkg::K_UNLOCK) unlock_q <= 1'b1;
      else if (exec && (kind_q == flash_cmd_pkg::K_LOCK || (needs_unlock && unlock_ok)
               || kind_q == flash_cmd_pkg::K_PAUSE)) unlock_q <= 1'b0;
      if (cs_rise && aligned && kind_q == flash_cmd_pkg::K_PD_IN) pd_q <= 1'b1;
      if (byte_done && ph_q == flash_cmd_pkg::PH_OPCODE
          && eff_kind == flash_cmd_pkg::K_PD_OUT) pd_q <= 1'b0;
      if (exec && kind_q == flash_cmd_pkg::K_OTP) otp_q <= 1'b1;
      wipe_whole_q <= whole_wipe;
    end
  end
  // command strobes, one cycle each
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_start <= 1'b0;
      prog_quad <= 1'b0;
      wipe_start <= 1'b0;
      wipe_size <= 2'h0;
      cmd_addr <= 24'h000000;
      pause_strobe <= 1'b0;
      continue_strobe <= 1'b0;
      unlock_clear_done <= 1'b0;
    end else begin
      prog_start <= exec && unlock_ok && (kind_q == flash_cmd_pkg::K_PROG1
                    || kind_q == flash_cmd_pkg::K_PROG4);
      prog_quad <= kind_q == flash_cmd_pkg::K_PROG4;
      wipe_start <= exec && unlock_ok && kind_q == flash_cmd_pkg::K_WIPE;
      wipe_size <= wipe_code(op_q);
      cmd_addr <= wipe_whole_q ? 24'h000000 : addr_q;
      pause_strobe <= exec && kind_q == flash_cmd_pkg::K_PAUSE && engine_busy;
      continue_strobe <= exec && kind_q == flash_cmd_pkg::K_CONT;
      unlock_clear_done <= exec && kind_q == flash_cmd_pkg::K_LOCK;
    end
  end
  // program data fifo toward the array engine
  data_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(fifo_push),
    .in_data(sh_next),
    .in_ready(fifo_ready),
    .out_valid(pd_valid),
    .out_data(pd_data),
    .out_ready(pd_ready),
    .flush(cs_fall)
  );
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) pd_overflow <= 1'b0;
    else if (cs_fall) pd_overflow <= 1'b0;
    else if (fifo_push && !fifo_ready) pd_overflow <= 1'b1;
  end
  assign power_down = pd_q;
  assign otp_window = otp_q;
  assign status_q_out = {status_q[7:2], unlock_q, status_q[0] | status_busy_bit};
  assign config_q_out = config_q;
  assign write_unlock_flag = unlock_q;
endmodule // serial_flash_command_decoder

// File: spi_host_model.sv
// host spi master model, mode 0, one serial half period is 8 sys_clk
// assumes one bench process calls its tasks
`timescale 1ns/10ps
module spi_host_model (
  // clock
  input wire logic sys_clk,
  // spi pins
  output logic chip_select_n = 1'b1,
  output logic serial_clk = 1'b0,
  output logic [3:0] sio_in = 4'hA,
  input wire logic [3:0] sio_out
);
  // wait one half period, then step off the edge
  task automatic half();
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  // select the device, serial clock idles low
  task automatic start();
    half();
    chip_select_n = 1'b0;
  endtask
  // send nb lane groups msb first, capture lane0 on each rise
  task automatic shift(input logic [7:0] tx, input int nb, input logic q,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      sio_in = q ? tx[7-4*i -: 4] : {~sio_in[3:1], tx[7-i]};
      half();
      serial_clk = 1'b1;
      rx = {rx[6:0], sio_out[0]};
      half();
      serial_clk = 1'b0;
    end
  endtask
  // deselect at whatever bit count was sent; released lanes flip
  task automatic stop();
    half();
    chip_select_n = 1'b1;
    sio_in = ~sio_in;
    half();
  endtask
endmodule // spi_host_model

// File: flash_cmd_asserts.sv
// assertions on the command decoder's ports
// assumes the bind below onto serial_flash_command_decoder
`timescale 1ns/10ps
module flash_cmd_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // watched ports
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic [3:0] sio_out,
  input wire logic [3:0] sio_oe_n,
  input wire logic engine_busy,
  input wire logic unlock_clear_done,
  input wire logic prog_start,
  input wire logic wipe_start,
  input wire logic [1:0] wipe_size,
  input wire logic [23:0] cmd_addr,
  input wire logic pause_strobe,
  input wire logic [7:0] status_q_out,
  input wire logic write_unlock_flag,
  input wire logic pd_valid,
  input wire logic [7:0] pd_data,
  input wire logic pd_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // flag gone soon after an executed command
  sequence flag_drops;
    ##[0:3] !write_unlock_flag;
  endsequence
  sequence exec_seen;
    prog_start || wipe_start;
  endsequence
  unlock_gate_prog_a: assert property (prog_start |-> $past(write_unlock_flag))
    else $error("program strobe while locked");
  unlock_gate_wipe_a: assert property (wipe_start |-> $past(write_unlock_flag))
    else $error("wipe strobe while locked");
  exec_clears_a: assert property (exec_seen |-> flag_drops)
    else $error("flag kept after execution");
  lock_clears_a: assert property (unlock_clear_done |-> flag_drops)
    else $error("flag kept after lock");
  flag_mirror_a: assert property (status_q_out[1] == write_unlock_flag)
    else $error("status bit1 differs from flag");
  strobe_pulse_a: assert property (exec_seen |=> !(prog_start || wipe_start))
    else $error("strobe longer than one cycle");
  after_cs_rise_a: assert property (exec_seen |-> $past(chip_select_n, 2))
    else $error("strobe before deselect");
  whole_wipe_addr_a: assert property (wipe_start && wipe_size == 2'h3 |-> cmd_addr == 24'h0)
    else $error("whole wipe with address");
  upper_lanes_a: assert property (sio_oe_n[3:1] == 3'h7)
    else $error("upper lane driven");
  drive_in_frame_a: assert property (!sio_oe_n[0] |-> !$past(chip_select_n, 7))
    else $error("lane0 driven while deselected");
  shift_on_fall_a: assert property
    ($changed(sio_out[0]) && !sio_oe_n[0] && $past(!sio_oe_n[0]) |-> !serial_clk)
    else $error("output moved while clock high");
  pd_hold_a: assert property (pd_valid && !pd_ready |=> pd_valid && $stable(pd_data))
    else $error("program data dropped while stalled");
  pause_busy_a: assert property (pause_strobe |-> $past(engine_busy))
    else $error("pause strobe while idle");
endmodule // flash_cmd_asserts
bind serial_flash_command_decoder flash_cmd_asserts u_chk (.sys_clk, .arst_n, .chip_select_n,
  .serial_clk, .sio_out, .sio_oe_n, .engine_busy, .unlock_clear_done, .prog_start, .wipe_start,
  .wipe_size, .cmd_addr, .pause_strobe, .status_q_out, .write_unlock_flag, .pd_valid,
  .pd_data, .pd_ready);

// File: tb_top.sv
// self-checking bench for the serial flash command decoder
// assumes spi_host_model drives the pins and the checker is bound
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] DEVICE = 8'h3C; // arbitrary value
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic engine_busy = 1'b0;
  logic status_busy_bit = 1'b0;
  logic pd_ready = 1'b0;
  logic chip_select_n, serial_clk, unlock_clear_done, prog_start, prog_quad, wipe_start;
  logic pause_strobe, continue_strobe, power_down, otp_window, write_unlock_flag;
  logic pd_valid, pd_overflow, got_quad;
  logic [3:0] sio_in, sio_out, sio_oe_n;
  logic [1:0] wipe_size, got_size;
  logic [23:0] cmd_addr, got_addr;
  logic [7:0] status_q_out, config_q_out, pd_data;
  int mismatches = 0, n_compared = 0, n_prog = 0, n_wipe = 0, n_pause = 0, n_cont = 0;
  int n_lock = 0;
  // design and host
  serial_flash_command_decoder #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE), .FIFO_DEPTH(32)) DUT (
    .sys_clk, .arst_n, .chip_select_n, .serial_clk, .sio_in, .sio_out, .sio_oe_n, .engine_busy,
    .status_busy_bit, .unlock_clear_done, .prog_start, .prog_quad, .wipe_start, .wipe_size,
    .cmd_addr, .pause_strobe, .continue_strobe, .power_down, .otp_window, .status_q_out,
    .config_q_out, .write_unlock_flag, .pd_valid, .pd_data, .pd_ready, .pd_overflow);
  spi_host_model host (.sys_clk, .chip_select_n, .serial_clk, .sio_in, .sio_out);
  always #2 sys_clk = ~sys_clk;
  // strobe counters and captured qualifiers
  always @(posedge sys_clk) begin
    if (prog_start === 1'b1) begin
      n_prog++;
      got_quad = prog_quad;
      got_addr = cmd_addr;
    end
    if (wipe_start === 1'b1) begin
      n_wipe++;
      got_size = wipe_size;
      got_addr = cmd_addr;
    end
    n_pause += int'(pause_strobe === 1'b1);
    n_cont += int'(continue_strobe === 1'b1);
    n_lock += int'(unlock_clear_done === 1'b1);
  end
  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // opcode then na address bytes, msb first
  task automatic head(input logic [7:0] op, input int na, input logic [23:0] a);
    logic [7:0] r;
    host.start();
    host.shift(op, 8, 1'b0, r);
    for (int i = na; i > 0; i--) host.shift(a[8*i-1 -: 8], 8, 1'b0, r);
  endtask
  // write-type frame, optionally with stray bits before deselect
  task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a, input int bits);
    logic [7:0] r;
    head(op, na, a);
    if (bits > 0) host.shift(8'hFF, bits, 1'b0, r);
    host.stop();
    repeat (16) @(posedge sys_clk);
    #1;
  endtask
  // read frame: np filler bytes (last one given), then two bytes out
  task automatic rd(input logic [7:0] op, input int np, input logic [7:0] last,
                    input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] r;
    head(op, 0, 24'h0);
    for (int i = 1; i <= np; i++) host.shift((i == np) ? last : 8'h00, 8, 1'b0, r);
    host.shift(8'h00, 8, 1'b0, r);
    chk(r, e0);
    host.shift(8'h00, 8, 1'b0, r);
    chk(r, e1);
    host.stop();
    repeat (16) @(posedge sys_clk);
    #1;
  endtask
  // program n bytes with the drain stalled, then drain and compare
  task automatic prog(input logic [7:0] op, input logic q, input int n);
    logic [7:0] r;
    int p, w;
    p = n_prog;
    cmd(8'h06, 0, 24'h0, 0);
    head(op, 3, 24'h0F0100);
    for (int k = 0; k < n; k++) host.shift(8'hA1 + k[7:0], q ? 2 : 8, q, r);
    host.stop();
    repeat (16) @(posedge sys_clk);
    #1;
    chk(n_prog, p + 1);
    chk(got_quad, q);
    chk(got_addr, 24'h0F0100);
    chk(pd_overflow, n > 32);
    pd_ready = 1'b1;
    for (int k = 0; k < (n > 32 ? 32 : n); k++) begin
      w = 0;
      while (pd_valid !== 1'b1 && w < 50) begin
        @(posedge sys_clk);
        #1;
        w++;
      end
      if (pd_valid !== 1'b1) begin
        mismatches++;
        report_and_stop();
      end
      chk(pd_data, 8'hA1 + k[7:0]);
      @(posedge sys_clk);
      #1;
    end
    pd_ready = 1'b0;
    chk(pd_valid, 1'b0);
  endtask
  task automatic t_lock_regs();
    cmd(8'h06, 0, 24'h0, 0);
    chk(write_unlock_flag, 1'b1);
    rd(8'h05, 0, 8'h00, 8'h02, 8'h02);
    status_busy_bit = 1'b1;
    rd(8'h05, 0, 8'h00, 8'h03, 8'h03);
    status_busy_bit = 1'b0;
    cmd(8'h04, 0, 24'h0, 0);
    chk(write_unlock_flag, 1'b0);
    chk(n_lock, 1);
    cmd(8'h06, 0, 24'h0, 0);
    cmd(8'h01, 2, 24'h0000C3, 0);
    chk(config_q_out, 8'hC3);
    rd(8'h15, 0, 8'h00, 8'hC3, 8'hC3);
    cmd(8'h01, 2, 24'h00003C, 0);
    chk(config_q_out, 8'hC3);
  endtask
  task automatic t_wipes();
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
    int p;
    for (int i = 0; i < 5; i++) begin
      p = n_wipe;
      cmd(8'h06, 0, 24'h0, 0);
      cmd(ops[i], i < 3 ? 3 : 0, 24'h123456, 0);
      chk(n_wipe, p + 1);
      chk(got_size, i < 3 ? i : 3);
      chk(got_addr, i < 3 ? 24'h123456 : 24'h0);
      chk(write_unlock_flag, 1'b0);
    end
    cmd(8'h20, 3, 24'h001000, 0);
    chk(n_wipe, p + 1);
    cmd(8'h06, 0, 24'h0, 0);
    cmd(8'h20, 3, 24'h001000, 4);
    chk(n_wipe, p + 1);
    cmd(8'h04, 0, 24'h0, 0);
  endtask
  task automatic t_pause_power();
    engine_busy = 1'b1;
    cmd(8'h75, 0, 24'h0, 0);
    cmd(8'hB0, 0, 24'h0, 0);
    chk(n_pause, 2);
    cmd(8'h7A, 0, 24'h0, 0);
    cmd(8'h30, 0, 24'h0, 0);
    chk(n_cont, 2);
    engine_busy = 1'b0;
    cmd(8'hB9, 0, 24'h0, 0);
    chk(power_down, 1'b1);
    cmd(8'h06, 0, 24'h0, 0);
    chk(write_unlock_flag, 1'b0);
    cmd(8'hAB, 0, 24'h0, 0);
    chk(power_down, 1'b0);
    rd(8'hAB, 3, 8'h00, DEVICE, DEVICE);
    rd(8'h90, 3, 8'h00, MAKER, DEVICE);
    rd(8'h90, 3, 8'h01, DEVICE, MAKER);
    cmd(8'hB1, 0, 24'h0, 0);
    chk(otp_window, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_lock_regs();
    t_wipes();
    prog(8'h02, 1'b0, 3);
    prog(8'h38, 1'b1, 33);
    t_pause_power();
    report_and_stop();
  end
endmodule // tb_top
